// [hw/ocmem_pkg.sv]
// Constants, types and carriers for the on-chip RAM and boot memory block.
// Assumes a single interconnect clock and one interface reset per memory.
//
// Operation
// - RAM: 64 KB single port, 64-bit data
// - Two reads, two writes, two total, round-robin
// - ECC bits stored; correct single, detect double
// - Responses returned in acceptance order
// - One transfer per clock, no turnaround bubbles
// - Resets never alter stored memory contents
// - Reset clears only slave interface state
// - Interconnect clock; separate active-low resets
// - Boot memory: 64 KB, 32-bit, one read
// - Boot memory writes get error, no change
// - Boot memory sustains one read per clock
// - No software-visible registers, arrays only
package ocmem_pkg;

    // ========================================
    // Sizes
    localparam int OCMEM_RAM_BYTES = 65536;
    localparam int OCMEM_RAM_DW = 64;
    localparam int OCMEM_ROM_BYTES = 65536;
    localparam int OCMEM_ROM_DW = 32;
    localparam int OCMEM_ADDR_W = 32;
    localparam int OCMEM_RAM_AW = $clog2(OCMEM_RAM_BYTES / (OCMEM_RAM_DW / 8));
    localparam int OCMEM_ROM_AW = $clog2(OCMEM_ROM_BYTES / (OCMEM_ROM_DW / 8));
    localparam int OCMEM_RAM_LSB = $clog2(OCMEM_RAM_DW / 8);
    localparam int OCMEM_ROM_LSB = $clog2(OCMEM_ROM_DW / 8);
    localparam int OCMEM_MAX_OUT = 2;
    localparam int OCMEM_CNT_W = 2;

    // ========================================
    // ECC code: SECDED over 64 data bits
    localparam int OCMEM_ECC_P = 7;
    localparam int OCMEM_ECC_W = OCMEM_ECC_P + 1;
    localparam int OCMEM_CW_W = OCMEM_RAM_DW + OCMEM_ECC_W;

    // ========================================
    // Response codes
    localparam logic [1:0] OCMEM_RESP_OKAY = 2'h0;
    localparam logic [1:0] OCMEM_RESP_SLVERR = 2'h2;

    // Response carrier
    typedef struct packed {
        logic is_write;
        logic [1:0] resp;
        logic [OCMEM_RAM_DW-1:0] data;
    } ocmem_rsp_s;

    typedef struct packed {
        logic [OCMEM_RAM_DW-1:0] data;
        logic single_err;
        logic double_err;
    } ocmem_dec_s;

endpackage : ocmem_pkg

// [hw/ocmem_ecc.sv]
// SECDED encoder and decoder for one 64-bit RAM word.
// Pure combinational; sits between the array and the response path.
`timescale 1ns/1ps
`default_nettype none
module ocmem_ecc
    import ocmem_pkg::*;
(
    // Encode side
    input wire logic [OCMEM_RAM_DW-1:0] enc_data,
    output logic [OCMEM_ECC_W-1:0] enc_check,
    // Decode side
    input wire logic [OCMEM_RAM_DW-1:0] dec_data,
    input wire logic [OCMEM_ECC_W-1:0] dec_check,
    output ocmem_dec_s dec_out
);

    // ========================================
    // Position code of each data bit: skip powers of two, Hamming style
    function automatic logic [OCMEM_ECC_P-1:0] pos_of(input int idx);
        int p;
        int n;
        p = 0;
        n = 0;
        for (int k = 1; k < 128; k++) begin
            if ((k & (k - 1)) != 0) begin
                if (n == idx) begin
                    p = k;
                end
                n++;
            end
        end
        return OCMEM_ECC_P'(p);
    endfunction : pos_of

    function automatic logic [OCMEM_ECC_P-1:0] syn_of(input logic [OCMEM_RAM_DW-1:0] d);
        logic [OCMEM_ECC_P-1:0] s;
        s = '0;
        for (int i = 0; i < OCMEM_RAM_DW; i++) begin
            if (d[i]) begin
                s = s ^ pos_of(i);
            end
        end
        return s;
    endfunction : syn_of

    logic [OCMEM_ECC_P-1:0] syn;
    logic par;

    // ========================================
    // Encoder: overall parity covers data and Hamming bits
    always_comb begin
        enc_check[OCMEM_ECC_P-1:0] = syn_of(enc_data);
        enc_check[OCMEM_ECC_W-1] = ^enc_data ^ ^syn_of(enc_data);
    end

    // ========================================
    // Decoder
    always_comb begin
        syn = syn_of(dec_data) ^ dec_check[OCMEM_ECC_P-1:0];
        par = ^dec_data ^ ^dec_check;
        dec_out.data = dec_data;
        dec_out.single_err = 1'b0;
        dec_out.double_err = 1'b0;
        if (par) begin
            dec_out.single_err = 1'b1;
            for (int i = 0; i < OCMEM_RAM_DW; i++) begin
                if (syn == pos_of(i)) begin
                    dec_out.data[i] = ~dec_data[i];
                end
            end
        end else if (syn != '0) begin
            dec_out.double_err = 1'b1;
        end
    end

endmodule : ocmem_ecc
`default_nettype wire

// [hw/ocmem_rom.sv]
// Boot memory slave: 32-bit read port, writes answered with an error.
// Contents are ROM_FILL XOR the word index, set at time zero; one read per clock.
`timescale 1ns/1ps
`default_nettype none
module ocmem_rom
    import ocmem_pkg::*;
#(
    parameter int DW = OCMEM_ROM_DW,
    parameter int AW = OCMEM_ROM_AW,
    parameter logic [DW-1:0] ROM_FILL = 32'h0000_0000
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    // Request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [OCMEM_ADDR_W-1:0] req_addr,
    output logic req_ready,
    // Response
    output logic rsp_valid,
    output logic rsp_is_write,
    output logic [1:0] rsp_resp,
    output logic [DW-1:0] rsp_data,
    input wire logic rsp_ready
);

    // ========================================
    // Array: never written, so no reset can disturb it
    logic [DW-1:0] rom [2**AW];
    initial begin
        for (int i = 0; i < 2**AW; i++) begin
            rom[i] = ROM_FILL ^ DW'(i);
        end
    end

    // ========================================
    // One-deep response stage; ready while it empties this cycle
    logic next_rsp_valid;
    logic next_rsp_is_write;
    logic [1:0] next_rsp_resp;
    logic [DW-1:0] next_rsp_data;
    logic take;

    always_comb begin
        req_ready = !rsp_valid || rsp_ready;
        take = req_valid && req_ready;
        next_rsp_valid = rsp_valid && !rsp_ready;
        next_rsp_is_write = rsp_is_write;
        next_rsp_resp = rsp_resp;
        next_rsp_data = rsp_data;
        if (take) begin
            next_rsp_valid = 1'b1;
            next_rsp_is_write = req_write;
            if (req_write) begin
                next_rsp_resp = OCMEM_RESP_SLVERR;
                next_rsp_data = '0;
            end else begin
                next_rsp_resp = OCMEM_RESP_OKAY;
                next_rsp_data = rom[req_addr[OCMEM_ROM_LSB +: AW]];
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rsp_valid <= 1'b0;
            rsp_is_write <= 1'b0;
            rsp_resp <= OCMEM_RESP_OKAY;
            rsp_data <= '0;
        end else if (clk_en) begin
            rsp_valid <= next_rsp_valid;
            rsp_is_write <= next_rsp_is_write;
            rsp_resp <= next_rsp_resp;
            rsp_data <= next_rsp_data;
        end
    end

endmodule : ocmem_rom
`default_nettype wire

// [hw/ocmem_top.sv]
// On-chip RAM with ECC and boot memory, both slaves of the interconnect.
// Assumes the interconnect handles security and drives both ports on one clock.
`timescale 1ns/1ps
`default_nettype none
module ocmem_top
    import ocmem_pkg::*;
#(
    parameter int RAM_DW = OCMEM_RAM_DW,
    parameter int RAM_AW = OCMEM_RAM_AW,
    parameter int MAX_OUT = OCMEM_MAX_OUT
) (
    // Interconnect clock and enable
    input wire logic main_interconnect_clock,
    input wire logic clk_en,
    // Interface resets, one per memory
    input wire logic ram_arst_n,
    input wire logic rom_arst_n,
    // RAM read request
    input wire logic ram_rd_valid,
    input wire logic [OCMEM_ADDR_W-1:0] ram_rd_addr,
    output logic ram_rd_ready,
    // RAM write request
    input wire logic ram_wr_valid,
    input wire logic [OCMEM_ADDR_W-1:0] ram_wr_addr,
    input wire logic [RAM_DW-1:0] ram_wr_data,
    input wire logic [RAM_DW/8-1:0] ram_wr_strb,
    output logic ram_wr_ready,
    // RAM response
    output logic ram_rsp_valid,
    output logic ram_rsp_is_write,
    output logic [1:0] ram_rsp_resp,
    output logic [RAM_DW-1:0] ram_rsp_data,
    input wire logic ram_rsp_ready,
    // RAM error events
    output logic ram_ecc_corrected,
    output logic ram_ecc_uncorrectable,
    // Boot memory request
    input wire logic rom_req_valid,
    input wire logic rom_req_write,
    input wire logic [OCMEM_ADDR_W-1:0] rom_req_addr,
    output logic rom_req_ready,
    // Boot memory response
    output logic rom_rsp_valid,
    output logic rom_rsp_is_write,
    output logic [1:0] rom_rsp_resp,
    output logic [OCMEM_ROM_DW-1:0] rom_rsp_data,
    input wire logic rom_rsp_ready
);

    // ========================================
    // Storage: data and check bits, no reset on the array
    logic [RAM_DW-1:0] mem_data [2**RAM_AW];
    logic [OCMEM_ECC_W-1:0] mem_check [2**RAM_AW];

    // ========================================
    // Response queue: two entries in acceptance order
    ocmem_rsp_s q [MAX_OUT];
    logic [OCMEM_CNT_W-1:0] q_cnt;
    ocmem_rsp_s next_q [MAX_OUT];
    logic [OCMEM_CNT_W-1:0] next_q_cnt;
    logic rr_last_wr;
    logic next_rr_last_wr;
    logic ev_corr;
    logic ev_unc;
    logic next_ev_corr;
    logic next_ev_unc;

    // ========================================
    // Arbitration and array access
    logic pop;
    logic room;
    logic grant_rd;
    logic grant_wr;
    logic [RAM_AW-1:0] rd_idx;
    logic [RAM_AW-1:0] wr_idx;
    logic [RAM_DW-1:0] old_word;
    logic [RAM_DW-1:0] merged;
    logic [OCMEM_ECC_W-1:0] merged_check;
    ocmem_dec_s rd_dec;
    ocmem_dec_s wr_dec;
    ocmem_rsp_s new_rsp;

    // Read path decoder
    ocmem_ecc u_ecc_rd (
        .enc_data(ram_wr_data),
        .enc_check(),
        .dec_data(mem_data[rd_idx]),
        .dec_check(mem_check[rd_idx]),
        .dec_out(rd_dec)
    );

    // Write path: decode the old word, merge strobes, re-encode
    ocmem_ecc u_ecc_wr (
        .enc_data(merged),
        .enc_check(merged_check),
        .dec_data(mem_data[wr_idx]),
        .dec_check(mem_check[wr_idx]),
        .dec_out(wr_dec)
    );

    assign rd_idx = ram_rd_addr[OCMEM_RAM_LSB +: RAM_AW];
    assign wr_idx = ram_wr_addr[OCMEM_RAM_LSB +: RAM_AW];
    assign old_word = wr_dec.data;

    // Byte merge per lane; a partial write scrubs the rest of the word
    for (genvar b = 0; b < RAM_DW / 8; b++) begin : g_lane
        assign merged[8*b +: 8] = ram_wr_strb[b] ? ram_wr_data[8*b +: 8] : old_word[8*b +: 8];
    end

    // Handshake and grant: the array serves one request per clock
    always_comb begin
        pop = ram_rsp_valid && ram_rsp_ready;
        room = (q_cnt < OCMEM_CNT_W'(MAX_OUT)) || pop;
        grant_rd = 1'b0;
        grant_wr = 1'b0;
        if (room) begin
            if (ram_rd_valid && ram_wr_valid) begin
                grant_wr = !rr_last_wr;
                grant_rd = rr_last_wr;
            end else begin
                grant_rd = ram_rd_valid;
                grant_wr = ram_wr_valid;
            end
        end
        ram_rd_ready = grant_rd;
        ram_wr_ready = grant_wr;
    end

    // Response entry built from the granted request
    always_comb begin
        new_rsp.is_write = grant_wr;
        new_rsp.resp = OCMEM_RESP_OKAY;
        new_rsp.data = '0;
        if (grant_rd) begin
            new_rsp.data = rd_dec.data;
            if (rd_dec.double_err) begin
                new_rsp.resp = OCMEM_RESP_SLVERR;
            end
        end
    end

    // ========================================
    // Queue next state; entries only shift, never reorder
    always_comb begin
        next_q = q;
        next_q_cnt = q_cnt;
        next_rr_last_wr = rr_last_wr;
        next_ev_corr = grant_rd && rd_dec.single_err;
        next_ev_unc = grant_rd && rd_dec.double_err;
        if (pop) begin
            next_q[0] = q[1];
            next_q_cnt = q_cnt - OCMEM_CNT_W'(1);
        end
        if (grant_rd || grant_wr) begin
            next_q[next_q_cnt[0]] = new_rsp;
            next_q_cnt = next_q_cnt + OCMEM_CNT_W'(1);
            next_rr_last_wr = grant_wr;
        end
    end

    always_ff @(posedge main_interconnect_clock or negedge ram_arst_n) begin
        if (!ram_arst_n) begin
            q_cnt <= '0;
            rr_last_wr <= 1'b0;
            ev_corr <= 1'b0;
            ev_unc <= 1'b0;
            for (int i = 0; i < MAX_OUT; i++) begin
                q[i] <= '0;
            end
        end else if (clk_en) begin
            q <= next_q;
            q_cnt <= next_q_cnt;
            rr_last_wr <= next_rr_last_wr;
            ev_corr <= next_ev_corr;
            ev_unc <= next_ev_unc;
        end
    end

    // Array write, untouched by reset so contents survive it
    always_ff @(posedge main_interconnect_clock) begin
        if (clk_en && grant_wr) begin
            mem_data[wr_idx] <= merged;
            mem_check[wr_idx] <= merged_check;
        end
    end

    // ========================================
    // Outputs: head of the queue, all from flip-flops
    always_comb begin
        ram_rsp_valid = (q_cnt != '0);
        ram_rsp_is_write = q[0].is_write;
        ram_rsp_resp = q[0].resp;
        ram_rsp_data = q[0].data;
        ram_ecc_corrected = ev_corr;
        ram_ecc_uncorrectable = ev_unc;
    end

    // ========================================
    // Boot memory; no security or register logic in either port
    ocmem_rom u_rom (
        .clock(main_interconnect_clock),
        .arst_n(rom_arst_n),
        .clk_en(clk_en),
        .req_valid(rom_req_valid),
        .req_write(rom_req_write),
        .req_addr(rom_req_addr),
        .req_ready(rom_req_ready),
        .rsp_valid(rom_rsp_valid),
        .rsp_is_write(rom_rsp_is_write),
        .rsp_resp(rom_rsp_resp),
        .rsp_data(rom_rsp_data),
        .rsp_ready(rom_rsp_ready)
    );

endmodule : ocmem_top
`default_nettype wire

// [test/ocmem_top_properties.sv]
// Checker for the RAM and boot memory slave ports of ocmem_top.
// Sees only top ports; assumes clk_en stays high while traffic runs.
`timescale 1ns/1ps
`default_nettype none
module ocmem_top_properties
    import ocmem_pkg::*;
#(
    parameter int RAM_DW = OCMEM_RAM_DW
) (
    // Clock, enable and resets
    input wire logic main_interconnect_clock,
    input wire logic clk_en,
    input wire logic ram_arst_n,
    input wire logic rom_arst_n,
    // RAM port
    input wire logic ram_rd_valid,
    input wire logic ram_rd_ready,
    input wire logic ram_wr_valid,
    input wire logic ram_wr_ready,
    input wire logic ram_rsp_valid,
    input wire logic ram_rsp_is_write,
    input wire logic [1:0] ram_rsp_resp,
    input wire logic [RAM_DW-1:0] ram_rsp_data,
    input wire logic ram_rsp_ready,
    // Boot memory port
    input wire logic rom_req_valid,
    input wire logic rom_req_write,
    input wire logic rom_req_ready,
    input wire logic rom_rsp_valid,
    input wire logic rom_rsp_is_write,
    input wire logic [1:0] rom_rsp_resp,
    input wire logic [31:0] rom_rsp_data,
    input wire logic rom_rsp_ready
);
    // ==========================================
    // Outstanding count, kept apart so a stuck queue shows up
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    always_comb begin
        next_cnt = cnt;
        if (clk_en) begin
            next_cnt = cnt + 3'(ram_rd_valid && ram_rd_ready) + 3'(ram_wr_valid && ram_wr_ready)
                - 3'(ram_rsp_valid && ram_rsp_ready);
        end
    end
    always_ff @(posedge main_interconnect_clock or negedge ram_arst_n) begin
        if (!ram_arst_n) begin
            cnt <= 3'h0;
        end else begin
            cnt <= next_cnt;
        end
    end
    default clocking cb @(posedge main_interconnect_clock); endclocking
    // ==========================================
    // RAM port
    a_ram_one_grant: assert property (disable iff (!ram_arst_n)
        !(ram_rd_valid && ram_rd_ready && ram_wr_valid && ram_wr_ready)) else $error("two grants in one cycle");
    a_ram_count_limit: assert property (disable iff (!ram_arst_n) cnt <= 3'h2)
        else $error("more than two outstanding");
    a_ram_full_refuse: assert property (disable iff (!ram_arst_n)
        (cnt == 3'h2 && !ram_rsp_ready) |-> !ram_rd_ready && !ram_wr_ready) else $error("accepted while full");
    a_ram_queue_valid: assert property (disable iff (!ram_arst_n) ram_rsp_valid == (cnt != 3'h0))
        else $error("response valid disagrees with pending count");
    a_ram_read_next: assert property (disable iff (!ram_arst_n)
        (clk_en && ram_rd_valid && ram_rd_ready && !ram_rsp_valid) |=> ram_rsp_valid && !ram_rsp_is_write)
        else $error("read response late");
    a_ram_write_next: assert property (disable iff (!ram_arst_n)
        (clk_en && ram_wr_valid && ram_wr_ready && !ram_rsp_valid)
        |=> ram_rsp_valid && ram_rsp_is_write && ram_rsp_resp == OCMEM_RESP_OKAY) else $error("write response bad");
    a_ram_rsp_hold: assert property (disable iff (!ram_arst_n)
        (ram_rsp_valid && !ram_rsp_ready) |=> ram_rsp_valid && $stable(ram_rsp_data) && $stable(ram_rsp_is_write))
        else $error("response changed while held");
    // ==========================================
    // Boot memory port
    a_rom_write_error: assert property (disable iff (!rom_arst_n)
        (clk_en && rom_req_valid && rom_req_ready && rom_req_write)
        |=> rom_rsp_valid && rom_rsp_resp == OCMEM_RESP_SLVERR && rom_rsp_data == 32'h0) else $error("write not refused");
    a_rom_read_okay: assert property (disable iff (!rom_arst_n)
        (clk_en && rom_req_valid && rom_req_ready && !rom_req_write)
        |=> rom_rsp_valid && !rom_rsp_is_write && rom_rsp_resp == OCMEM_RESP_OKAY) else $error("read answer bad");
    a_rom_ready_rule: assert property (disable iff (!rom_arst_n)
        rom_req_ready == (!rom_rsp_valid || rom_rsp_ready)) else $error("boot ready wrong");
    c_ram_full: cover property (disable iff (!ram_arst_n) cnt == 3'h2 && ram_rd_valid);
    c_ram_turn: cover property (disable iff (!ram_arst_n) ram_wr_valid && ram_wr_ready ##1 ram_rd_valid && ram_rd_ready);
    c_rom_error: cover property (disable iff (!rom_arst_n) rom_rsp_valid && rom_rsp_resp == OCMEM_RESP_SLVERR);
endmodule : ocmem_top_properties
bind ocmem_top ocmem_top_properties #(.RAM_DW(RAM_DW)) u_props (.*);
`default_nettype wire

// [test/ocmem_master_model.sv]
// Interconnect master model: accepts responses promptly, slowly or not at all.
// Mode comes from the bench; changes land on the next clock edge.
`timescale 1ns/1ps
`default_nettype none
module ocmem_master_model (
    // Clock and mode: 0 prompt, 1 alternate, 2 stalled
    input wire logic clock,
    input wire logic [1:0] mode,
    // Response acceptance
    output logic ram_rsp_ready = 1'b0,
    output logic rom_rsp_ready = 1'b0
);
    // No security attribute is sent; each memory is treated uniformly
    logic phase = 1'b0;
    always @(posedge clock) begin
        phase <= !phase;
        ram_rsp_ready <= (mode == 2'h0) || (mode == 2'h1 && phase);
        rom_rsp_ready <= (mode == 2'h0) || (mode == 2'h1 && !phase);
    end
endmodule : ocmem_master_model
`default_nettype wire

// [test/test_onchip_ram_and_boot_rom.sv]
// Self-checking bench for ocmem_top with the interconnect master model.
// RAM words are written before read, as the array starts unknown.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module test_onchip_ram_and_boot_rom
    import ocmem_pkg::*;
;
    logic clock = 1'b0;
    logic ram_arst_n = 1'b0;
    logic rom_arst_n = 1'b0;
    logic ram_rd_valid = 1'b0;
    logic ram_wr_valid = 1'b0;
    logic [31:0] ram_rd_addr = 32'h0;
    logic [31:0] ram_wr_addr = 32'h0;
    logic [63:0] ram_wr_data = 64'h0;
    logic [7:0] ram_wr_strb = 8'h0;
    logic rom_req_valid = 1'b0;
    logic rom_req_write = 1'b0;
    logic [31:0] rom_req_addr = 32'h0;
    logic [1:0] mode = 2'h0;
    logic ram_rd_ready, ram_wr_ready, ram_rsp_valid, ram_rsp_is_write, ram_rsp_ready;
    logic rom_req_ready, rom_rsp_valid, rom_rsp_is_write, rom_rsp_ready;
    logic [1:0] ram_rsp_resp, rom_rsp_resp;
    logic [63:0] ram_rsp_data;
    logic [31:0] rom_rsp_data;
    logic ram_ecc_corrected, ram_ecc_uncorrectable;
    logic [63:0] shadow [8192];
    logic [66:0] ram_exp [$];
    logic [34:0] rom_exp [$];
    logic [66:0] ram_head;
    logic [34:0] rom_head;
    int fail_count = 0;
    int total_checks = 0;
    ocmem_top dut (.main_interconnect_clock(clock), .clk_en(1'b1), .ram_arst_n(ram_arst_n),
        .rom_arst_n(rom_arst_n), .ram_rd_valid(ram_rd_valid), .ram_rd_addr(ram_rd_addr),
        .ram_rd_ready(ram_rd_ready), .ram_wr_valid(ram_wr_valid), .ram_wr_addr(ram_wr_addr),
        .ram_wr_data(ram_wr_data), .ram_wr_strb(ram_wr_strb), .ram_wr_ready(ram_wr_ready),
        .ram_rsp_valid(ram_rsp_valid), .ram_rsp_is_write(ram_rsp_is_write), .ram_rsp_resp(ram_rsp_resp),
        .ram_rsp_data(ram_rsp_data), .ram_rsp_ready(ram_rsp_ready), .ram_ecc_corrected(ram_ecc_corrected),
        .ram_ecc_uncorrectable(ram_ecc_uncorrectable), .rom_req_valid(rom_req_valid), .rom_req_write(rom_req_write),
        .rom_req_addr(rom_req_addr), .rom_req_ready(rom_req_ready), .rom_rsp_valid(rom_rsp_valid),
        .rom_rsp_is_write(rom_rsp_is_write), .rom_rsp_resp(rom_rsp_resp), .rom_rsp_data(rom_rsp_data),
        .rom_rsp_ready(rom_rsp_ready));
    ocmem_master_model u_master (.clock(clock), .mode(mode), .ram_rsp_ready(ram_rsp_ready),
        .rom_rsp_ready(rom_rsp_ready));
    initial forever #5 clock = ~clock;
    // ==========================================
    // Response monitor: everything must come back in issue order
    // Heads are popped once before comparing, as the macro reads its expected value twice
    always @(posedge clock) begin
        if (ram_arst_n === 1'b1) begin
            `CHK({ram_ecc_corrected, ram_ecc_uncorrectable}, 2'h0)
        end
        if (ram_rsp_valid === 1'b1 && ram_rsp_ready === 1'b1) begin
            ram_head = ram_exp.pop_front();
            `CHK({ram_rsp_is_write, ram_rsp_resp, ram_rsp_data}, ram_head)
        end
        if (rom_rsp_valid === 1'b1 && rom_rsp_ready === 1'b1) begin
            rom_head = rom_exp.pop_front();
            `CHK({rom_rsp_is_write, rom_rsp_resp, rom_rsp_data}, rom_head)
        end
    end
    // ==========================================
    // Bus tasks
    task automatic ram_op(input logic wr, input logic [31:0] a, input logic [63:0] d, input logic [7:0] s);
        logic [63:0] w;
        w = shadow[a[15:3]];
        for (int b = 0; b < 8; b++) begin
            if (wr && s[b]) w[8*b +: 8] = d[8*b +: 8];
        end
        if (wr) shadow[a[15:3]] = w;
        ram_exp.push_back(wr ? {1'b1, OCMEM_RESP_OKAY, 64'h0} : {1'b0, OCMEM_RESP_OKAY, w});
        ram_wr_valid <= wr;
        ram_rd_valid <= !wr;
        ram_wr_addr <= a;
        ram_rd_addr <= a;
        ram_wr_data <= d;
        ram_wr_strb <= s;
        do @(posedge clock); while ((wr ? ram_wr_ready : ram_rd_ready) !== 1'b1);
    endtask : ram_op
    task automatic rom_op(input logic wr, input logic [31:0] a);
        rom_exp.push_back({wr, wr ? OCMEM_RESP_SLVERR : OCMEM_RESP_OKAY, wr ? 32'h0 : {18'h0, a[15:2]}});
        rom_req_valid <= 1'b1;
        rom_req_write <= wr;
        rom_req_addr <= a;
        do @(posedge clock); while (rom_req_ready !== 1'b1);
    endtask : rom_op
    task automatic idle_drain();
        ram_rd_valid <= 1'b0;
        ram_wr_valid <= 1'b0;
        rom_req_valid <= 1'b0;
        repeat (12) @(posedge clock);
        `CHK(ram_exp.size() + rom_exp.size(), 0)
    endtask : idle_drain
    // ==========================================
    // Scenarios
    task automatic t_back_to_back();
        time t0;
        mode <= 2'h0;
        @(posedge clock);
        t0 = $time;
        ram_op(1'b1, 32'h0, 64'h0123_4567_89AB_CDEF, 8'hFF);
        ram_op(1'b1, 32'hFFF8, 64'hFEDC_BA98_7654_3210, 8'hFF);
        ram_op(1'b0, 32'h0, 64'h0, 8'h0);
        ram_op(1'b1, 32'h10, 64'h5555_AAAA_0F0F_F0F0, 8'hFF);
        ram_op(1'b0, 32'hFFF8, 64'h0, 8'h0);
        ram_op(1'b0, 32'h10, 64'h0, 8'h0);
        `CHK($time - t0, 60)
        ram_op(1'b1, 32'h8000_0000, 64'hAAAA_BBBB_CCCC_DDDD, 8'h0F);
        ram_op(1'b0, 32'h0, 64'h0, 8'h0);
        idle_drain();
    endtask : t_back_to_back
    task automatic t_round_robin();
        logic got_r;
        logic got_w;
        got_r = 1'b0;
        got_w = 1'b0;
        ram_exp.push_back({1'b1, OCMEM_RESP_OKAY, 64'h0});
        shadow[13'h2] = 64'h1122_3344_5566_7788;
        ram_exp.push_back({1'b0, OCMEM_RESP_OKAY, shadow[13'h2]});
        ram_rd_addr <= 32'h10;
        ram_wr_addr <= 32'h10;
        ram_wr_data <= 64'h1122_3344_5566_7788;
        ram_wr_strb <= 8'hFF;
        ram_rd_valid <= 1'b1;
        ram_wr_valid <= 1'b1;
        while (!(got_r && got_w)) begin
            @(posedge clock);
            if (ram_rd_valid && ram_rd_ready === 1'b1) got_r = 1'b1;
            if (ram_wr_valid && ram_wr_ready === 1'b1) got_w = 1'b1;
            // Last step is left to idle_drain, one assignment per time step
            if (!(got_r && got_w)) begin
                ram_rd_valid <= !got_r;
                ram_wr_valid <= !got_w;
            end
        end
        idle_drain();
    endtask : t_round_robin
    task automatic t_stall();
        mode <= 2'h2;
        ram_op(1'b0, 32'h0, 64'h0, 8'h0);
        ram_op(1'b0, 32'h10, 64'h0, 8'h0);
        ram_rd_addr <= 32'hFFF8;
        ram_wr_valid <= 1'b1;
        repeat (3) @(posedge clock);
        `CHK({ram_rd_ready, ram_wr_ready}, 2'h0)
        mode <= 2'h0;
        ram_op(1'b0, 32'hFFF8, 64'h0, 8'h0);
        idle_drain();
    endtask : t_stall
    task automatic t_reset_keep();
        mode <= 2'h2;
        ram_op(1'b0, 32'h0, 64'h0, 8'h0);
        ram_rd_valid <= 1'b0;
        rom_op(1'b0, 32'h4);
        rom_req_valid <= 1'b0;
        void'(ram_exp.pop_back());
        void'(rom_exp.pop_back());
        repeat (2) @(posedge clock);
        ram_arst_n <= 1'b0;
        rom_arst_n <= 1'b0;
        @(posedge clock);
        `CHK({ram_rsp_valid, rom_rsp_valid}, 2'h0)
        repeat (2) @(posedge clock);
        ram_arst_n <= 1'b1;
        rom_arst_n <= 1'b1;
        mode <= 2'h0;
        @(posedge clock);
        ram_op(1'b0, 32'h0, 64'h0, 8'h0);
        ram_op(1'b0, 32'hFFF8, 64'h0, 8'h0);
        idle_drain();
    endtask : t_reset_keep
    task automatic t_boot();
        time t0;
        t0 = $time;
        rom_op(1'b0, 32'h0);
        rom_op(1'b0, 32'h1234_0008);
        rom_op(1'b0, 32'hFFFC);
        `CHK($time - t0, 30)
        mode <= 2'h1;
        rom_op(1'b1, 32'h8);
        rom_op(1'b0, 32'h8);
        rom_op(1'b0, 32'h4);
        idle_drain();
    endtask : t_boot
    task automatic final_report();
        if (fail_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (20) @(posedge clock);
        ram_arst_n <= 1'b1;
        rom_arst_n <= 1'b1;
        @(posedge clock);
        t_back_to_back();
        t_round_robin();
        t_stall();
        t_reset_keep();
        t_boot();
        final_report();
    end
    initial begin
        repeat (3000) @(posedge clock);
        fail_count++;
        final_report();
    end
endmodule : test_onchip_ram_and_boot_rom
`default_nettype wire
